/* design/iic_top.sv */
// Sixteen-channel isolated input port with change-of-state interrupt.
// Holds the byte-wide host registers, the arm state and the sticky interrupt.
// Assumes a host byte bus already decoded to the board's eight addresses,
// on the same clock as this block, with strobes that stay high for a whole cycle.
// Field inputs are asynchronous; filter and line selects are static straps.
// Overview of operation
// - Eight consecutive byte offsets are picked by addr once the outside base decode asserts cs.
// - All accesses are single 8-bit bytes.
// - Sixteen independent inputs are monitored for level changes.
// - Reading offset two arms change-of-state interrupts and returns the arm bit.
// - While armed, any edge that passes an input's filter raises the interrupt.
// - Writing offset one clears the pending interrupt.
// - Interrupt stays asserted until software clears it.
// - Writing offset two disarms; a later read re-arms.
// - Interrupt drives one host line chosen by static select, none if the select names a masked system line.
// - Per-channel slow filter 4.7 ms, else about 10 us.
`timescale 1ns/1ns
`default_nettype none
`include "iic_cfg.svh"
module iic_top
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic cs,
    input wire logic [2:0] addr,
    input wire logic rd,
    input wire logic wr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic rdata_en,
    input wire logic [15:0] inputs,
    input wire logic [15:0] slow_filter_sel,
    input wire logic [3:0] irq_sel,
    output logic [15:0] irq_lines,
    output logic irq_pending
);
    iic_pkg::iic_bus_req_t req;
    iic_pkg::iic_acc_t acc_r;
    logic [15:0] level;
    logic [15:0] prev_r;
    logic [15:0] chg;
    logic armed_r;
    logic rd_pulse;
    logic wr_pulse;
    logic change;
    logic hit_clear;
    logic hit_arm;

    // Lines of system devices are masked out, so a bad select cannot collide with them.
    // A masked select leaves the interrupt silent rather than misrouted.
    localparam logic [15:0] line_ok = `IIC_IRQ_OK;

    // ****************************************
    // Bus request
    // ****************************************
    // The base compare sits outside; cs marks the eight offsets and addr picks one.
    assign req = '{addr: addr, wdata: wdata, rd: rd & cs, wr: wr & cs};

    // ****************************************
    // Offset decode
    // ****************************************
    // Data offsets are decoded in the read mux; these two carry the strobes.
    assign hit_clear = (req.addr == `IIC_OFS_CLEAR);
    assign hit_arm = (req.addr == `IIC_OFS_ARM);

    // ****************************************
    // Strobe edge detection
    // ****************************************
    // A strobe may last many clocks; it arms, disarms or clears only on its first cycle.
    // Held strobes are refused after that, so a slow host cannot re-arm twice.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            acc_r <= iic_pkg::IIC_IDLE;
        end
        else if (req.rd | req.wr)
        begin
            acc_r <= iic_pkg::IIC_BUSY;
        end
        else
        begin
            acc_r <= iic_pkg::IIC_IDLE;
        end
    end
    assign rd_pulse = req.rd & (acc_r == iic_pkg::IIC_IDLE);
    assign wr_pulse = req.wr & (acc_r == iic_pkg::IIC_IDLE);

    // ****************************************
    // Input channels
    // ****************************************
    // Each channel has its own synchroniser and filter, so a slow one never delays a fast one.
    genvar i;
    generate
        for (i = 0; i < `IIC_NCH; i++)
        begin : g_ch
            iic_filter u_filt
            (
                .mclk(mclk),
                .reset(reset),
                .raw(inputs[i]),
                .slow_sel(slow_filter_sel[i]),
                .level(level[i])
            );
            // Either direction of a level move counts.
            assign chg[i] = level[i] ^ prev_r[i];
        end
    endgenerate

    // ****************************************
    // Change detection
    // ****************************************
    // Clears to the filters' reset level, so no false change follows reset.
    // Inputs already high at reset still show one change once filtered, while disarmed.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            prev_r <= 16'h0000;
        end
        else
        begin
            prev_r <= level;
        end
    end
    assign change = |chg;

    // ****************************************
    // Arm state
    // ****************************************
    // A disarm write outranks a re-arm read; one strobe never carries both.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            armed_r <= `IIC_ARM_RST;
        end
        else if (wr_pulse && hit_arm)
        begin
            armed_r <= 1'b0;
        end
        else if (rd_pulse && hit_arm)
        begin
            armed_r <= 1'b1;
        end
    end

    // ****************************************
    // Pending interrupt
    // ****************************************
    // An edge in the clearing cycle wins so no change is lost.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            irq_pending <= `IIC_PEND_RST;
        end
        else if (armed_r && change)
        begin
            irq_pending <= 1'b1;
        end
        else if (wr_pulse && hit_clear)
        begin
            irq_pending <= 1'b0;
        end
    end

    // ****************************************
    // Interrupt routing
    // ****************************************
    // Only the selected line follows the pending flag, and only if it is permitted; the rest stay low.
    genvar j;
    generate
        for (j = 0; j < `IIC_NLINE; j++)
        begin : g_line
            assign irq_lines[j] = irq_pending & line_ok[j] & (irq_sel == 4'(j));
        end
    endgenerate

    // ****************************************
    // Read data
    // ****************************************
    // Byte-wide only: the sixteen inputs show as two bytes, spare offsets read zero.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            rdata <= 8'h00;
        end
        else if (req.rd)
        begin
            unique case (req.addr)
                `IIC_OFS_DATA_LO:
                begin
                    rdata <= level[7:0];
                end
                `IIC_OFS_DATA_HI:
                begin
                    rdata <= level[15:8];
                end
                `IIC_OFS_ARM:
                begin
                    rdata <= {7'h00, armed_r};
                end
                default:
                begin
                    rdata <= 8'h00;
                end
            endcase
        end
    end

    // ****************************************
    // Read drive enable
    // ****************************************
    // Combinational so the host data bus is driven in the very cycle of the read.
    assign rdata_en = req.rd;
endmodule
`default_nettype wire

/* design/iic_cfg.svh */
// Constants for the isolated input change-of-state port.
// Assumes a 10 MHz system clock; included by bare name.
`ifndef IIC_CFG_SVH
`define IIC_CFG_SVH
`define IIC_OFS_DATA_LO 3'h0
`define IIC_OFS_CLEAR 3'h1
`define IIC_OFS_ARM 3'h2
`define IIC_OFS_DATA_HI 3'h3
`define IIC_CLK_HZ 10000000
`define IIC_SLOW_TC_US 4700
`define IIC_FAST_TC_US 10
`define IIC_SLOW_CYC ((`IIC_SLOW_TC_US * (`IIC_CLK_HZ / 1000000)))
`define IIC_FAST_CYC ((`IIC_FAST_TC_US * (`IIC_CLK_HZ / 1000000)))
`define IIC_CNT_W 16
`define IIC_NCH 16
`define IIC_IRQ_W 4
`define IIC_NLINE 16
// Host lines that may carry the interrupt; the others belong to system devices
`define IIC_IRQ_OK 16'hDCFC
`define IIC_ARM_RST 1'b0
`define IIC_PEND_RST 1'b0
`endif

/* design/iic_pkg.sv */
// Types for the isolated input change-of-state port.
// Assumes iic_cfg.svh supplies the constants.
`include "iic_cfg.svh"
package iic_pkg;
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } iic_bus_req_t;
    typedef enum logic [1:0] {
        IIC_IDLE = 2'b01,
        IIC_BUSY = 2'b10
    } iic_acc_t;
endpackage

/* design/iic_filter.sv */
// One input channel: two-flop synchroniser and a hold-off filter.
// Assumes a raw asynchronous input and a static filter select.
`timescale 1ns/1ns
`default_nettype none
`include "iic_cfg.svh"
module iic_filter
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic raw,
    input wire logic slow_sel,
    output logic level
);
    logic sync1_r;
    logic sync2_r;
    logic [`IIC_CNT_W-1:0] cnt_r;
    logic [`IIC_CNT_W-1:0] limit;

    // ****************************************
    // Synchroniser
    // ****************************************
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end
        else
        begin
            sync1_r <= raw;
            sync2_r <= sync1_r;
        end
    end

    // ****************************************
    // Filter
    // ****************************************
    // A new level is accepted only after it has held for the whole time constant,
    // so AC ripple on a slow channel never toggles the output.
    assign limit = slow_sel ? `IIC_CNT_W'(`IIC_SLOW_CYC) : `IIC_CNT_W'(`IIC_FAST_CYC);

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            cnt_r <= 16'h0000;
            level <= 1'b0;
        end
        else if (sync2_r == level)
        begin
            cnt_r <= 16'h0000;
        end
        else if (cnt_r >= limit - 16'h0001)
        begin
            cnt_r <= 16'h0000;
            level <= sync2_r;
        end
        else
        begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end
endmodule
`default_nettype wire

/* test/iic_host_model.sv */
// Host bus model: single byte strobes into the port.
// Assumes the port samples on the rising edge of mclk.
`timescale 1ns/1ns
`default_nettype none
module iic_host_model
(
    input wire logic mclk,
    output logic cs,
    output logic [2:0] addr,
    output logic rd,
    output logic wr,
    output logic [7:0] wdata
);
    initial {cs, addr, rd, wr, wdata} = 14'h0;
    // Released address and data lines show the inverse and strobes drop low, so stale values never look valid
    task automatic acc(input logic w, input logic [2:0] a);
        @(negedge mclk);
        {cs, addr, rd, wr, wdata} = {1'b1, a, ~w, w, 8'hA5};
        @(negedge mclk);
        {cs, addr, rd, wr, wdata} = {1'b0, ~a, 2'b00, 8'h5A};
        @(negedge mclk);
    endtask
endmodule
`default_nettype wire

/* test/iic_top_sva.sv */
// Checker for the change-of-state port, bound to iic_top.
// Assumes strobes act only in their first cycle.
`timescale 1ns/1ns
`default_nettype none
`include "iic_cfg.svh"
module iic_top_sva
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic cs,
    input wire logic [2:0] addr,
    input wire logic rd,
    input wire logic wr,
    input wire logic [7:0] rdata,
    input wire logic rdata_en,
    input wire logic [3:0] irq_sel,
    input wire logic [15:0] irq_lines,
    input wire logic irq_pending
);
    logic prev_r;
    logic armed_r;
    logic first;
    assign first = cs && (rd || wr) && !prev_r;
    always_ff @(posedge mclk or posedge reset)
        if (reset)
            prev_r <= 1'b0;
        else
            prev_r <= cs && (rd || wr);
    // Shadow of the arm state, followed from the bus alone
    always_ff @(posedge mclk or posedge reset)
        if (reset)
            armed_r <= 1'b0;
        else if (first && addr == 3'h2)
            armed_r <= rd;
    localparam logic [15:0] line_ok = `IIC_IRQ_OK;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    AST_RDEN: assert property (rdata_en == (rd && cs)) else $error("drive enable wrong");
    AST_LINES: assert property (irq_lines ==
        ((irq_pending && line_ok[irq_sel]) ? 16'h0001 << irq_sel : 16'h0000))
        else $error("irq line wrong");
    AST_ROSE: assert property ($rose(irq_pending) |-> $past(armed_r)) else $error("irq while disarmed");
    AST_FELL: assert property ($fell(irq_pending) |-> $past(first && wr && addr == 3'h1))
        else $error("irq dropped uncleared");
    AST_STICKY: assert property (irq_pending && !(first && wr && addr == 3'h1) |=> irq_pending)
        else $error("irq not sticky");
    AST_RST: assert property ($fell(reset) |-> !irq_pending && rdata == 8'h00)
        else $error("reset state");
    AST_ARM: assert property (first && rd && addr == 3'h2 |=> rdata == {7'h00, $past(armed_r)})
        else $error("arm read data");
    AST_RDZ: assert property (first && rd && (addr == 3'h1 || addr > 3'h3) |=> rdata == 8'h00)
        else $error("unused read not zero");
    cover property ($rose(irq_pending));
    cover property ($fell(irq_pending));
    cover property (first && wr && addr == 3'h2);
    cover property (first && rd && addr == 3'h2 && !armed_r);
endmodule
bind iic_top iic_top_sva u_iic_top_sva (.mclk(mclk), .reset(reset), .cs(cs), .addr(addr), .rd(rd), .wr(wr),
    .rdata(rdata), .rdata_en(rdata_en), .irq_sel(irq_sel), .irq_lines(irq_lines), .irq_pending(irq_pending));
`default_nettype wire

/* test/iic_top_tb_top.sv */
// Testbench for the change-of-state port.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
module iic_top_tb_top;
    logic mclk, reset, cs, rd, wr, rdata_en, irq_pending;
    logic [2:0] addr;
    logic [7:0] wdata, rdata;
    logic [15:0] inputs, slow_filter_sel, irq_lines;
    logic [3:0] irq_sel;
    int errors;
    int check_count;
    iic_host_model u_iic_host_model (.mclk(mclk), .cs(cs), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata));
    iic_top u_iic_top (.mclk(mclk), .reset(reset), .cs(cs), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata),
        .rdata(rdata), .rdata_en(rdata_en), .inputs(inputs), .slow_filter_sel(slow_filter_sel),
        .irq_sel(irq_sel), .irq_lines(irq_lines), .irq_pending(irq_pending));
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic h(input logic w, input logic [2:0] a);
        u_iic_host_model.acc(w, a);
    endtask
    // Fast filter is 100 cycles, so 130 leaves room for sync and compare
    task automatic flip(input int b);
        @(negedge mclk);
        inputs[b] = ~inputs[b];
        repeat (130) @(negedge mclk);
    endtask
    initial
    begin
        #6000000;
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test();
    end
    initial
    begin
        {reset, inputs, slow_filter_sel, irq_sel, errors, check_count} = {1'b1, 16'h0, 16'h0100, 4'h5, 64'h0};
        repeat (5) @(negedge mclk);
        reset = 1'b0;
        chk(irq_pending, 16'h0000, "pending after reset");
        h(1'b0, 3'h2);
        chk(rdata, 16'h0000, "armed after reset");
        h(1'b1, 3'h1);
        h(1'b0, 3'h2);
        h(1'b0, 3'h2);
        chk(rdata, 16'h0001, "arm bit");
        flip(0);
        chk(irq_lines, 16'h0020, "selected line");
        irq_sel = 4'h1;
        @(negedge mclk);
        chk(irq_lines, 16'h0000, "system line driven");
        irq_sel = 4'hE;
        @(negedge mclk);
        chk(irq_lines, 16'h4000, "upper line");
        irq_sel = 4'h5;
        h(1'b0, 3'h0);
        chk(rdata, 16'h0001, "low byte");
        h(1'b0, 3'h4);
        chk(rdata, 16'h0000, "spare offset");
        chk(irq_pending, 16'h0001, "not sticky");
        h(1'b1, 3'h1);
        chk(irq_pending, 16'h0000, "not cleared");
        flip(0);
        chk(irq_pending, 16'h0001, "falling edge missed");
        h(1'b1, 3'h1);
        flip(15);
        h(1'b0, 3'h3);
        chk(rdata, 16'h0080, "high byte");
        chk(irq_pending, 16'h0001, "rising edge missed");
        h(1'b1, 3'h1);
        h(1'b1, 3'h2);
        flip(3);
        chk(irq_pending, 16'h0000, "edge while disarmed");
        h(1'b0, 3'h2);
        chk(rdata, 16'h0000, "disarm bit");
        flip(8);
        chk(irq_pending, 16'h0000, "slow filter too fast");
        repeat (47000) @(negedge mclk);
        chk(irq_pending, 16'h0001, "slow edge missed");
        reset = 1'b1;
        repeat (3) @(negedge mclk);
        reset = 1'b0;
        chk(irq_pending, 16'h0000, "pending after second reset");
        flip(1);
        chk(irq_pending, 16'h0000, "armed after second reset");
        h(1'b0, 3'h2);
        chk(rdata, 16'h0000, "arm bit after second reset");
        end_of_test();
    end
endmodule
`default_nettype wire
